// File: hw/acp_cmd_parser.sv
`timescale 1ns/1ps
`include "acp_defines.svh"

// Operation
// - Two-letter name, required parameter, case-blind
// - Act only after carriage return byte
// - Number, default or query forms, checked per command
// - Integer-only commands reject fractional numbers
// - Highest mass number set by variant
// - Query replies end with LF then CR
// - Ion current sent as four bytes, LSB first
// - Low supply sets supply bit 6, status 6
// - Failed power-up supply check: power off, error on
// - Overpressure with filament on kills it, lights error and leak
// - Emission failure sets filament bit 6, status 1
// - RF max failure sets mass-filter bit 7, status 4
// - Unknown name: no reply, flash, comms bits
// - Status and four error bytes each queryable
// - Some queries retest, others clear after read
// - Error steady for bits 1-7, two flashes for 0
module acp_cmd_parser #(
    parameter int unsigned MASS_MAX  = `ACP_MASS_MAX_DEF,
    parameter int unsigned FLASH_CYC = `ACP_FLASH_CYC
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              rxValid,       // Host byte strobe
    input  wire logic [7:0]        rxData,
    output logic                   rxReady,
    output logic                   txValid,
    output logic [7:0]             txData,
    input  wire logic              txReady,
    input  wire logic              ionValid,      // Ion reading to send
    input  wire logic [31:0]       ionWord,
    input  wire acp_pkg::acp_fault_s faults,      // One-cycle check events
    input  wire logic              powerUpCheck,  // High while power-up check runs
    input  wire logic              filamentOn,
    output logic                   filamentOff,   // Pulse: shut filament down
    output logic                   supplyRetest,  // Pulse: rerun supply test
    output logic                   cmdValid,      // Pulse: other command to execute
    output acp_pkg::acp_parsed_s   cmdOut,
    output logic                   badParam,      // Pulse: parameter form or value not allowed
    output logic [7:0]             statusByte,
    output acp_pkg::acp_leds_s     leds
);

    // -------------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------------
    function automatic logic [7:0] upcase(input logic [7:0] c);
        upcase = (c >= 8'h61 && c <= 8'h7a) ? (c & ~`ACP_CASE_BIT) : c;
    endfunction

    function automatic logic isDigit(input logic [7:0] c);
        isDigit = (c >= `ACP_CH_ZERO) && (c <= `ACP_CH_NINE);
    endfunction

    function automatic acp_pkg::acp_cmd_e decode(input logic [15:0] n);
        unique case (n)
            16'h4552: decode = acp_pkg::ACP_CMD_QUERY_STATUS;
            16'h4550: decode = acp_pkg::ACP_CMD_QUERY_SUPPLY;
            16'h4546: decode = acp_pkg::ACP_CMD_QUERY_FILAMENT;
            16'h4551: decode = acp_pkg::ACP_CMD_QUERY_MASSFILTER;
            16'h4543: decode = acp_pkg::ACP_CMD_QUERY_COMMS;
            16'h4944, 16'h494e, 16'h4447, 16'h4545, 16'h464c,
            16'h4d4c, 16'h4d49, 16'h4d46: decode = acp_pkg::ACP_CMD_OTHER;
            default:  decode = acp_pkg::ACP_CMD_UNKNOWN;
        endcase
    endfunction

    // -------------------------------------------------------------------------
    // Receive parser
    // -------------------------------------------------------------------------
    typedef enum logic [1:0] {
        ACP_RX_NAME0,
        ACP_RX_NAME1,
        ACP_RX_PARAM,
        ACP_RX_FLUSH
    } acp_rx_e;

    acp_rx_e             rxState_q;   // Parser position
    acp_pkg::acp_parsed_s par_q;      // Command being assembled
    logic                paramBad_q;  // Malformed parameter text
    logic                txBusy;      // Framer occupied
    logic                done;        // Terminator seen this cycle
    logic                rxTake;
    logic [7:0]          ch;

    assign rxReady = !txBusy;
    assign rxTake  = rxValid && rxReady;
    assign ch      = upcase(rxData);
    assign done    = rxTake && (rxData == `ACP_CH_CR);

    // Collect name and parameter characters until the terminator
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rxState_q  <= ACP_RX_NAME0;
            par_q      <= '0;
            paramBad_q <= 1'b0;
        end else if (done) begin
            rxState_q  <= ACP_RX_NAME0;
        end else if (rxTake) begin
            unique case (rxState_q)
                ACP_RX_NAME0: begin
                    par_q      <= '0;
                    paramBad_q <= 1'b0;
                    par_q.name[15:8] <= ch;
                    rxState_q  <= ACP_RX_NAME1;
                end
                ACP_RX_NAME1: begin
                    par_q.name[7:0] <= ch;
                    rxState_q       <= ACP_RX_PARAM;
                end
                ACP_RX_PARAM: begin
                    // Classify the parameter by its first character
                    if (rxData == `ACP_CH_STAR && par_q.form == acp_pkg::ACP_PAR_NONE) begin
                        par_q.form <= acp_pkg::ACP_PAR_DEFAULT;
                    end else if (rxData == `ACP_CH_QUERY
                                 && par_q.form == acp_pkg::ACP_PAR_NONE) begin
                        par_q.form <= acp_pkg::ACP_PAR_QUERY;
                    end else if (rxData == `ACP_CH_MINUS
                                 && par_q.form == acp_pkg::ACP_PAR_NONE) begin
                        par_q.negative <= 1'b1;
                        par_q.form     <= acp_pkg::ACP_PAR_NUM;
                    end else if (rxData == `ACP_CH_DOT && !par_q.isReal
                                 && par_q.form inside {acp_pkg::ACP_PAR_NONE,
                                                       acp_pkg::ACP_PAR_NUM}) begin
                        par_q.isReal <= 1'b1;
                        par_q.form   <= acp_pkg::ACP_PAR_NUM;
                    end else if (isDigit(rxData)
                                 && par_q.form inside {acp_pkg::ACP_PAR_NONE,
                                                       acp_pkg::ACP_PAR_NUM}) begin
                        par_q.form <= acp_pkg::ACP_PAR_NUM;
                        // Only the integer part is kept
                        if (!par_q.isReal) begin
                            par_q.value <= 16'(par_q.value * 16'd10
                                               + 16'(rxData - `ACP_CH_ZERO));
                        end
                    end else begin
                        paramBad_q <= 1'b1;
                    end
                end
                default: rxState_q <= rxState_q;
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // Command check at the terminator
    // -------------------------------------------------------------------------
    acp_pkg::acp_cmd_e kind;
    logic              nameOk;
    logic              isErrQuery;
    logic              formOk;

    assign kind       = decode(par_q.name);
    assign nameOk     = (rxState_q == ACP_RX_PARAM) && (kind != acp_pkg::ACP_CMD_UNKNOWN);
    assign isErrQuery = nameOk && (kind != acp_pkg::ACP_CMD_OTHER);
    // Error queries take only the query form; every other name needs a parameter
    assign formOk = !paramBad_q && (isErrQuery ? (par_q.form == acp_pkg::ACP_PAR_QUERY)
                                               : (par_q.form != acp_pkg::ACP_PAR_NONE));

    // Mass commands: integer part bounded by the variant constant
    logic massOver;
    assign massOver = (par_q.name inside {16'h4d4c, 16'h4d49, 16'h4d46})
                      && par_q.form == acp_pkg::ACP_PAR_NUM
                      && par_q.value > 16'(MASS_MAX);
    // Integer-only commands (mass range, energy, degas, init)
    logic realBad;
    assign realBad = par_q.isReal && (par_q.name inside {16'h4d49, 16'h4d46, 16'h4545,
                                                         16'h4447, 16'h494e});

    // Hand all but the error queries to the executive
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cmdValid <= 1'b0;
            cmdOut   <= '0;
            badParam <= 1'b0;
        end else begin
            cmdValid <= done && nameOk && !isErrQuery && formOk && !massOver && !realBad;
            badParam <= done && nameOk && (!formOk || massOver || realBad);
            if (done) begin
                cmdOut <= par_q;
            end
        end
    end

    // -------------------------------------------------------------------------
    // Error bytes
    // -------------------------------------------------------------------------
    logic [7:0] supplyErr_q;
    logic [7:0] filamentErr_q;
    logic [7:0] massFilterErr_q;
    logic [7:0] commsErr_q;
    logic       badName;
    logic       queryFire;

    assign badName   = done && !nameOk;
    assign queryFire = done && isErrQuery && formOk;

    // Supply: cleared by its query, set again by the check, including the retest that follows
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            supplyErr_q <= `ACP_ERR_RESET;
        end else if (faults.lowSupply) begin
            supplyErr_q[`ACP_LOW_SUPPLY_BIT] <= 1'b1;
        end else if (queryFire && kind == acp_pkg::ACP_CMD_QUERY_SUPPLY) begin
            supplyErr_q <= `ACP_ERR_RESET;
        end
    end

    // Filament, mass filter and comms: clear on read, new event wins
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            filamentErr_q   <= `ACP_ERR_RESET;
            massFilterErr_q <= `ACP_ERR_RESET;
            commsErr_q      <= `ACP_ERR_RESET;
        end else begin
            if (queryFire && kind == acp_pkg::ACP_CMD_QUERY_FILAMENT) begin
                filamentErr_q <= `ACP_ERR_RESET;
            end
            if (faults.emissionFail || (faults.overPressure && filamentOn)) begin
                filamentErr_q[`ACP_EMISSION_FAIL_BIT] <= 1'b1;
            end
            if (queryFire && kind == acp_pkg::ACP_CMD_QUERY_MASSFILTER) begin
                massFilterErr_q <= `ACP_ERR_RESET;
            end
            if (faults.rfMaxFail) begin
                massFilterErr_q[`ACP_RF_MAX_FAIL_BIT] <= 1'b1;
            end
            if (queryFire && kind == acp_pkg::ACP_CMD_QUERY_COMMS) begin
                commsErr_q <= `ACP_ERR_RESET;
            end
            if (badName) begin
                commsErr_q[`ACP_BAD_CMD_BIT] <= 1'b1;
            end
        end
    end

    // Status summarises the error bytes
    always_comb begin
        statusByte = 8'h00;
        statusByte[`ACP_ST_COMMS]  = |commsErr_q;
        statusByte[`ACP_ST_FIL]    = |filamentErr_q;
        statusByte[`ACP_ST_QMF]    = |massFilterErr_q;
        statusByte[`ACP_ST_SUPPLY] = |supplyErr_q;
    end

    // Supply query replies first, then retests; the check reports through faults
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            supplyRetest <= 1'b0;
        end else begin
            supplyRetest <= queryFire && kind == acp_pkg::ACP_CMD_QUERY_SUPPLY;
        end
    end

    // -------------------------------------------------------------------------
    // Reply selection
    // -------------------------------------------------------------------------
    logic [7:0] replyByte;
    always_comb begin
        unique case (kind)
            acp_pkg::ACP_CMD_QUERY_SUPPLY:     replyByte = supplyErr_q;
            acp_pkg::ACP_CMD_QUERY_FILAMENT:   replyByte = filamentErr_q;
            acp_pkg::ACP_CMD_QUERY_MASSFILTER: replyByte = massFilterErr_q;
            acp_pkg::ACP_CMD_QUERY_COMMS:      replyByte = commsErr_q;
            default:                           replyByte = statusByte;
        endcase
    end

    // Unknown names never start a reply
    acp_tx_framer u_framer (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .startText (queryFire),
        .textByte  (replyByte),
        .startIon  (ionValid && !queryFire),
        .ionWord   (ionWord),
        .busy      (txBusy),
        .txValid   (txValid),
        .txData    (txData),
        .txReady   (txReady)
    );

    // -------------------------------------------------------------------------
    // Front-panel indicators
    // -------------------------------------------------------------------------
    logic [31:0] flashCnt_q;   // Cycles within one flash phase
    logic [2:0]  flashPh_q;    // Remaining on/off phases
    logic        supplyFail_q; // Latched failed power-up supply check
    logic        filOff_q;     // Filament killed by overpressure
    logic        leak_q;

    // Two flashes: four phases, odd ones lit
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flashCnt_q <= 32'h0000_0000;
            flashPh_q  <= 3'd0;
        end else if (badName) begin
            flashCnt_q <= 32'h0000_0000;
            flashPh_q  <= 3'(`ACP_FLASH_PHASES);
        end else if (flashPh_q != 3'd0) begin
            if (flashCnt_q == FLASH_CYC - 1) begin
                flashCnt_q <= 32'h0000_0000;
                flashPh_q  <= flashPh_q - 3'd1;
            end else begin
                flashCnt_q <= flashCnt_q + 32'd1;
            end
        end
    end

    // Supply failure at power-up and overpressure protection
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            supplyFail_q <= 1'b0;
            filOff_q     <= 1'b0;
            leak_q       <= 1'b0;
            filamentOff  <= 1'b0;
        end else begin
            if (powerUpCheck && faults.lowSupply) begin
                supplyFail_q <= 1'b1;
            end
            filamentOff <= faults.overPressure && filamentOn;
            if (faults.overPressure && filamentOn) begin
                leak_q   <= 1'b1;
                filOff_q <= 1'b1;
            end else if (filamentOn && !filOff_q) begin
                leak_q <= 1'b0;
            end
            if (!filamentOn) begin
                filOff_q <= 1'b0;
            end
        end
    end

    // Steady error for bits 1-7, flashed only for comms
    always_comb begin
        leds.power    = !supplyFail_q;
        leds.error    = (|statusByte[7:1]) || supplyFail_q || leak_q
                        || flashPh_q[0];
        leds.filament = filamentOn && !filOff_q;
        leds.leak     = leak_q;
    end

endmodule

// File: hw/acp_defines.svh
`ifndef ACP_DEFINES_SVH
`define ACP_DEFINES_SVH

// Character codes
`define ACP_CH_CR        8'h0d
`define ACP_CH_LF        8'h0a
`define ACP_CH_STAR      8'h2a
`define ACP_CH_QUERY     8'h3f
`define ACP_CH_DOT       8'h2e
`define ACP_CH_MINUS     8'h2d
`define ACP_CH_ZERO      8'h30
`define ACP_CH_NINE      8'h39
`define ACP_CASE_BIT     8'h20

// Status byte bit positions
`define ACP_ST_COMMS     0
`define ACP_ST_FIL       1
`define ACP_ST_QMF       4
`define ACP_ST_SUPPLY    6

// Error byte bit positions
`define ACP_LOW_SUPPLY_BIT    6
`define ACP_EMISSION_FAIL_BIT 6
`define ACP_RF_MAX_FAIL_BIT   7
`define ACP_BAD_CMD_BIT       0

// Reset values
`define ACP_ERR_RESET    8'h00

// Mass limit default (variant 100, 200 or 300)
`define ACP_MASS_MAX_DEF 100

// Error indicator flash: two flashes, each phase this long
`define ACP_FLASH_NS     200000000
`define ACP_CLK_NS       100
`define ACP_FLASH_CYC    (`ACP_FLASH_NS / `ACP_CLK_NS)
`define ACP_FLASH_PHASES 4

// Ion current word length in bytes
`define ACP_ION_BYTES    4

`endif

// File: hw/acp_pkg.sv
package acp_pkg;

    // Parameter form that followed the command name
    typedef enum logic [1:0] {
        ACP_PAR_NONE,
        ACP_PAR_NUM,
        ACP_PAR_DEFAULT,
        ACP_PAR_QUERY
    } acp_par_e;

    // Decoded command names handled here
    typedef enum logic [2:0] {
        ACP_CMD_UNKNOWN,
        ACP_CMD_QUERY_STATUS,
        ACP_CMD_QUERY_SUPPLY,
        ACP_CMD_QUERY_FILAMENT,
        ACP_CMD_QUERY_MASSFILTER,
        ACP_CMD_QUERY_COMMS,
        ACP_CMD_OTHER
    } acp_cmd_e;

    // Parsed command handed to the executive
    typedef struct packed {
        logic [15:0] name;
        acp_par_e    form;
        logic        isReal;
        logic        negative;
        logic [15:0] value;
    } acp_parsed_s;

    // Hardware check events from the analog side
    typedef struct packed {
        logic lowSupply;
        logic emissionFail;
        logic rfMaxFail;
        logic overPressure;
    } acp_fault_s;

    // Front-panel indicators
    typedef struct packed {
        logic power;
        logic error;
        logic filament;
        logic leak;
    } acp_leds_s;

endpackage

// File: hw/acp_tx_framer.sv
`timescale 1ns/1ps
`include "acp_defines.svh"

// -----------------------------------------------------------------------------
// Reply framer: ASCII byte + LF CR, or raw four-byte ion word, LSB first
// -----------------------------------------------------------------------------
module acp_tx_framer (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        startText,  // Send textByte then LF CR
    input  wire logic [7:0]  textByte,
    input  wire logic        startIon,   // Send ionWord as four bytes
    input  wire logic [31:0] ionWord,
    output logic             busy,
    output logic             txValid,
    output logic [7:0]       txData,
    input  wire logic        txReady
);

    logic [31:0] shift_q;     // Bytes still to go, next in low byte
    logic [2:0]  left_q;      // Bytes remaining in the frame

    // Handshake combinational, data from flops
    assign busy    = (left_q != 3'd0);
    assign txValid = busy;
    assign txData  = shift_q[7:0];

    // Load a frame or shift out one byte per accepted beat
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            shift_q <= 32'h0000_0000;
            left_q  <= 3'd0;
        end else if (!busy && startIon) begin
            shift_q <= ionWord;
            left_q  <= 3'(`ACP_ION_BYTES);
        end else if (!busy && startText) begin
            shift_q <= {8'h00, `ACP_CH_CR, `ACP_CH_LF, textByte};
            left_q  <= 3'd3;
        end else if (busy && txReady) begin
            shift_q <= {8'h00, shift_q[31:8]};
            left_q  <= left_q - 3'd1;
        end
    end

endmodule

// File: dv/acp_host_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------
// Host model: sends queued bytes, collects replies
// ----------------------------------------------------------
module acp_host_model (
    input  wire logic       clk_sys,
    output logic            rxValid,
    output logic [7:0]      rxData,
    input  wire logic       rxReady,
    input  wire logic       txValid,
    input  wire logic [7:0] txData,
    output logic            txReady,
    input  wire logic       slow     // Stall every other cycle
);
    byte unsigned sendQ[$];  // Bytes still to send
    byte unsigned recvQ[$];  // Reply bytes seen
    logic         stall;     // Stall phase
    initial begin
        rxValid = 1'b0;
        rxData  = 8'h00;
        txReady = 1'b1;
        stall   = 1'b0;
    end
    // Handshakes are judged at the rising edge, before updates land
    always @(posedge clk_sys) begin
        if (rxValid && rxReady) begin
            void'(sendQ.pop_front());
        end
        if (txValid && txReady) begin
            recvQ.push_back(txData);
        end
    end
    // Idle data toggles between the last byte and its inverse each cycle
    always @(negedge clk_sys) begin
        rxValid <= (sendQ.size() != 0);
        rxData  <= (sendQ.size() != 0) ? sendQ[0] : ~rxData;
        stall = slow && !stall;
        txReady <= !stall;
    end
endmodule

// File: dv/acp_cmd_parser_props.sv
`timescale 1ns/1ps

// ----------------------------------------------------------
// Port checks for the command parser
// ----------------------------------------------------------
module acp_cmd_parser_props (
    input wire logic                clk_sys,
    input wire logic                rst_n,
    input wire logic                rxValid,
    input wire logic [7:0]          rxData,
    input wire logic                rxReady,
    input wire logic                txValid,
    input wire logic [7:0]          txData,
    input wire logic                txReady,
    input wire acp_pkg::acp_fault_s faults,
    input wire logic                powerUpCheck,
    input wire logic                filamentOn,
    input wire logic                filamentOff,
    input wire logic                cmdValid,
    input wire logic                badParam,
    input wire logic [7:0]          statusByte,
    input wire acp_pkg::acp_leds_s  leds
);
    logic crTaken_q;  // Terminator taken on last edge
    // Results may only follow a terminator
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            crTaken_q <= 1'b0;
        end else begin
            crTaken_q <= rxValid && rxReady && (rxData == 8'h0d);
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_act_on_cr: assert property ((cmdValid || badParam) |-> crTaken_q || $past(crTaken_q))
        else $error("command result without terminator");
    a_low_supply: assert property (faults.lowSupply |=> statusByte[6])
        else $error("supply status bit not set");
    a_emis_fail: assert property (faults.emissionFail |=> statusByte[1])
        else $error("filament status bit not set");
    a_rf_fail: assert property (faults.rfMaxFail |=> statusByte[4])
        else $error("mass filter status bit not set");
    a_overp_kill: assert property (faults.overPressure && filamentOn |=> filamentOff && leds.error && leds.leak)
        else $error("overpressure not handled");
    a_err_steady: assert property (|statusByte[7:1] |-> leds.error)
        else $error("error indicator off with fault");
    a_power_fail: assert property (powerUpCheck && faults.lowSupply |=> !leds.power && leds.error)
        else $error("power indicator left on");
    a_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txData))
        else $error("reply byte dropped while stalled");
endmodule

bind acp_cmd_parser acp_cmd_parser_props props_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .rxValid(rxValid), .rxData(rxData),
    .rxReady(rxReady), .txValid(txValid), .txData(txData), .txReady(txReady),
    .faults(faults), .powerUpCheck(powerUpCheck), .filamentOn(filamentOn),
    .filamentOff(filamentOff), .cmdValid(cmdValid), .badParam(badParam),
    .statusByte(statusByte), .leds(leds)
);

// File: dv/acp_cmd_parser_bench.sv
`timescale 1ns/1ps

// ----------------------------------------------------------
// Self-checking bench for the command parser
// ----------------------------------------------------------
module acp_cmd_parser_bench;
    logic clk_sys, rst_n, rxValid, rxReady, txValid, txReady, ionValid;
    logic powerUpCheck, filamentOn, filamentOff, supplyRetest, cmdValid;
    logic badParam, slow, errPrev;
    logic [7:0] rxData, txData, statusByte;
    logic [31:0] ionWord, rnd;
    acp_pkg::acp_fault_s faults;
    acp_pkg::acp_leds_s leds;
    acp_pkg::acp_parsed_s cmdOut;
    int fails, checked, nCmd, nBad, nOff, nRise, c0, b0, r0, nRet;
    int errB[5];  // Model error bytes: supply, filament, mass filter, comms
    string qs[6] = '{"Er?", "ep?", "Ef?", "eQ?", "ec?", "eR?"};
    string cs[6] = '{"EE*", "ML250", "ml99.5", "MI2.5", "DG", "iD?"};
    bit okc[6] = '{1, 0, 1, 0, 0, 1};

    acp_host_model hostU (.clk_sys(clk_sys), .rxValid(rxValid), .rxData(rxData),
        .rxReady(rxReady), .txValid(txValid), .txData(txData), .txReady(txReady), .slow(slow));
    acp_cmd_parser #(.MASS_MAX(100), .FLASH_CYC(4)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
        .rxValid(rxValid), .rxData(rxData), .rxReady(rxReady), .txValid(txValid),
        .txData(txData), .txReady(txReady), .ionValid(ionValid), .ionWord(ionWord),
        .faults(faults), .powerUpCheck(powerUpCheck), .filamentOn(filamentOn),
        .filamentOff(filamentOff), .supplyRetest(supplyRetest), .cmdValid(cmdValid),
        .cmdOut(cmdOut), .badParam(badParam), .statusByte(statusByte), .leds(leds));

    // Clock at 100 ns
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // Pulse counters, sampled before the edge's updates land
    always @(posedge clk_sys) begin
        nCmd += cmdValid;
        nBad += badParam;
        nOff += filamentOff;
        nRet += supplyRetest;
        errPrev <= leds.error;
        if (leds.error && !errPrev) nRise++;
    end
    function automatic int stat();
        return (errB[1] != 0 ? 64 : 0) | (errB[2] != 0 ? 2 : 0) | (errB[3] != 0 ? 16 : 0)
            | (errB[4] != 0 ? 1 : 0);
    endfunction
    function automatic logic [31:0] xs(logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction
    task chk(logic [31:0] got, logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Queue a command, wait for it to drain and settle
    task send(string s, bit cr);
        for (int i = 0; i < s.len(); i++) hostU.sendQ.push_back(s[i]);
        if (cr) hostU.sendQ.push_back(8'h0d);
        for (int i = 0; i < 80 && hostU.sendQ.size() != 0; i++) @(negedge clk_sys);
        repeat (14) @(negedge clk_sys);
    endtask
    task reply(int v);
        chk(hostU.recvQ.size(), 3);
        if (hostU.recvQ.size() == 3) begin
            chk(hostU.recvQ[0], v);
            chk(hostU.recvQ[1], 8'h0a);
            chk(hostU.recvQ[2], 8'h0d);
        end
        hostU.recvQ.delete();
    endtask
    task fire(acp_pkg::acp_fault_s f);
        faults = f;
        @(negedge clk_sys);
        faults = 4'h0;
        @(negedge clk_sys);
    endtask
    task finish_test();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Watchdog, well past the expected run length
    initial begin
        repeat (8000) @(posedge clk_sys);
        fails++;
        finish_test();
    end
    initial begin
        {rst_n, ionValid, ionWord, powerUpCheck, filamentOn, slow} = 0;
        faults = 4'h0;
        rnd = 32'h1d7d;
        errB = '{default: 0};
        repeat (3) @(negedge clk_sys);
        rst_n = 1'b1;
        @(negedge clk_sys);
        chk(statusByte, 8'h00);
        chk(leds, 4'h8);
        $display("test reset done");
        fire(4'he);
        errB[1:3] = '{64, 64, 128};
        chk(statusByte, stat());
        for (int k = 0; k < 6; k++) begin
            send(qs[k], 1);
            reply(k % 5 == 0 ? stat() : errB[k]);
            if (k % 5 != 0) errB[k] = 0;
        end
        chk(nRet, 1);
        $display("test queries done");
        r0 = nRise;
        send("IM?", 1);
        errB[4] = 1;
        chk(hostU.recvQ.size(), 0);
        chk(statusByte, stat());
        repeat (40) @(negedge clk_sys);
        chk(nRise - r0, 2);
        send("eC?", 1);
        reply(1);
        $display("test unknown done");
        for (int k = 0; k < 6; k++) begin
            {c0, b0} = {nCmd, nBad};
            send(cs[k], 1);
            chk(nCmd - c0, okc[k]);
            chk(nBad - b0, !okc[k]);
        end
        c0 = nCmd;
        send("ee70", 0);
        chk(nCmd - c0, 0);
        send("", 1);
        chk(nCmd - c0, 1);
        chk(cmdOut.name, 16'h4545);
        chk(cmdOut.value, 16'd70);
        $display("test params done");
        slow = 1'b1;
        for (int k = 0; k < 3; k++) begin
            rnd = xs(rnd);
            ionWord = rnd;
            ionValid = 1'b1;
            @(negedge clk_sys);
            ionValid = 1'b0;
            repeat (20) @(negedge clk_sys);
            chk(hostU.recvQ.size(), 4);
            for (int b = 0; b < hostU.recvQ.size() && b < 4; b++) chk(hostU.recvQ[b], rnd[8*b +: 8]);
            hostU.recvQ.delete();
        end
        $display("test ion done");
        filamentOn = 1'b1;
        c0 = nOff;
        fire(4'h1);
        chk(nOff - c0, 1);
        chk({leds.error, leds.leak, leds.filament}, 3'h6);
        filamentOn = 1'b0;
        powerUpCheck = 1'b1;
        fire(4'h8);
        chk({leds.power, leds.error}, 2'h1);
        chk(statusByte[6], 1'b1);
        $display("test faults done");
        finish_test();
    end
endmodule
